// ==== logic/drswp_core.sv ====
// Role-swap feature flags and swap state-machine input qualification.
// Assumes line state, requests and strobes are synchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
module drswp_core (
   input wire logic clk_in, // 10 MHz device clock
   input wire logic sys_rst_in, // Synchronous reset, active high
   input wire logic swap_capable_in, // Device supports role swap
   input wire logic is_host_side_in, // Device is acting as default host
   input wire logic [1:0] line_state_in, // Bus line state
   input wire logic bus_reset_in, // Bus reset detected
   input wire logic session_end_in, // Session end
   input wire logic feat_strobe_in, // Uncorrupted feature request
   input wire logic feat_set_in, // High for SetFeature, low for ClearFeature
   input wire logic [7:0] feat_sel_in, // Feature selector
   input wire logic [1:0] dev_state_in, // 0 default,1 address,2 configured
   input wire logic config_select_in, // Non-default configuration selected
   input wire logic host_disconnect_in, // Far end disconnect while acting host
   input wire logic host_done_in, // Acting host finished with the bus
   input wire logic supply_pulse_in, // Supply pulsing detected
   input wire logic data_pulse_in, // Data-line pulsing detected
   input wire logic supply_fall_entry_in, // Entering host_await_supply_fall
   input wire logic periph_attach_in, // Peripheral attach qualified
   input wire logic host_app_wants_bus_in, // Host application bus request
   input wire logic host_app_power_down_in, // Host application power down
   input wire logic periph_app_wants_bus_in, // Peripheral application bus request
   output logic feat_ack_out, // Feature request acknowledged
   output logic feat_stall_out, // Feature request stalled
   output logic role_swap_granted_out, // Swap granted flag
   output logic host_port_swap_capable_out, // Host port swap capable flag
   output logic other_port_swap_capable_out, // Other port swap capable flag
   output logic swap_allowed_out, // Swap allowed
   output logic use_other_port_out, // Advise other receptacle
   output logic swap_unsupported_out, // Swap unsupported here
   output logic host_suspend_seen_out, // Peripheral saw host suspend
   output logic host_resume_seen_out, // Peripheral saw host resume
   output logic host_side_attached_out, // Peripheral saw host attach
   output logic reset_inferred_out, // Long SE0 taken as bus reset
   output logic periph_suspend_seen_out, // Host saw peripheral suspend
   output logic periph_resume_seen_out, // Host saw peripheral resume
   output logic session_request_seen_out, // Session request seen
   output logic pullup_en_out, // D+ pull-up enable
   output logic [1:0] periph_state_out, // Peripheral-side role state
   output logic [1:0] host_state_out // Host-side role state
);
   drswp_pkg::drswp_pstate_t p_reg;
   drswp_pkg::drswp_hstate_t h_reg;
   logic [1:0] prev_ls_reg;
   logic [drswp_pkg::CNT_W-1:0] idle_cnt_reg;
   logic [drswp_pkg::CNT_W-1:0] se0_cnt_reg;
   logic [drswp_pkg::CNT_W-1:0] dis_cnt_reg;
   logic [drswp_pkg::CNT_W-1:0] att_cnt_reg;
   logic idle_long, se0_long, discharged, j_to_k, non_idle, flag_clear, feat_ours, p_leave;
   logic host_quiet;

   function automatic logic cnt_hit(input logic [drswp_pkg::CNT_W-1:0] c,
                                    input int unsigned lim);
      cnt_hit = c >= drswp_pkg::CNT_W'(lim);
   endfunction

   // Saturates so a very long condition never wraps back below a threshold
   function automatic logic [drswp_pkg::CNT_W-1:0] cnt_step(
      input logic [drswp_pkg::CNT_W-1:0] c, input logic run);
      if (!run) begin
         cnt_step = '0;
      end else if (&c) begin
         cnt_step = c;
      end else begin
         cnt_step = c + drswp_pkg::CNT_W'(1);
      end
   endfunction

   assign j_to_k = (prev_ls_reg == drswp_pkg::LS_J) && (line_state_in == drswp_pkg::LS_K);
   assign non_idle = line_state_in != drswp_pkg::LS_J;
   assign idle_long = cnt_hit(idle_cnt_reg, drswp_pkg::IDLE_SUSPEND_CYC);
   assign se0_long = cnt_hit(se0_cnt_reg, drswp_pkg::RESET_INFER_CYC);
   assign discharged = cnt_hit(dis_cnt_reg, drswp_pkg::RESIDUAL_DISCHARGE_CYC);
   assign flag_clear = bus_reset_in || session_end_in;
   // Power-down implies no bus use even if the request pin is late to drop
   assign host_quiet = !host_app_wants_bus_in || host_app_power_down_in;
   assign feat_ours = (feat_sel_in == drswp_pkg::SEL_ROLE_SWAP_GRANTED) ||
                      (feat_sel_in == drswp_pkg::SEL_HOST_PORT_SWAP) ||
                      (feat_sel_in == drswp_pkg::SEL_OTHER_PORT_SWAP);

   // Line history and counters
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         // Idle history, so a K in the first cycle after reset reads as J-to-K
         prev_ls_reg <= drswp_pkg::LS_J;
         idle_cnt_reg <= '0;
         se0_cnt_reg <= '0;
      end else begin
         prev_ls_reg <= line_state_in;
         idle_cnt_reg <= cnt_step(idle_cnt_reg, line_state_in == drswp_pkg::LS_J);
         se0_cnt_reg <= cnt_step(se0_cnt_reg, line_state_in == drswp_pkg::LS_SE0);
      end
   end

   // Discharge wait then D+ high debounce, only while awaiting host attach
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         dis_cnt_reg <= '0;
         att_cnt_reg <= '0;
      end else begin
         dis_cnt_reg <= cnt_step(dis_cnt_reg, p_reg == drswp_pkg::PERIPH_AWAIT_HOST_ATTACH);
         att_cnt_reg <= cnt_step(att_cnt_reg, (p_reg == drswp_pkg::PERIPH_AWAIT_HOST_ATTACH)
                        && discharged && (line_state_in == drswp_pkg::LS_J));
      end
   end

   // Feature flags
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         role_swap_granted_out <= 1'b0;
         host_port_swap_capable_out <= 1'b0;
         other_port_swap_capable_out <= 1'b0;
         feat_ack_out <= 1'b0;
         feat_stall_out <= 1'b0;
      end else begin
         feat_ack_out <= 1'b0;
         feat_stall_out <= 1'b0;
         // A clear in the same cycle beats a SetFeature
         if (flag_clear) begin
            role_swap_granted_out <= 1'b0;
            host_port_swap_capable_out <= 1'b0;
            other_port_swap_capable_out <= 1'b0;
         end else if (feat_strobe_in && feat_set_in && feat_ours) begin
            if (!swap_capable_in) begin
               feat_stall_out <= 1'b1;
            end else if (dev_state_in != 2'h3) begin
               feat_ack_out <= 1'b1;
               if (feat_sel_in == drswp_pkg::SEL_ROLE_SWAP_GRANTED) begin
                  role_swap_granted_out <= 1'b1;
               end
               if (feat_sel_in == drswp_pkg::SEL_HOST_PORT_SWAP) begin
                  host_port_swap_capable_out <= 1'b1;
               end
               if (feat_sel_in == drswp_pkg::SEL_OTHER_PORT_SWAP) begin
                  other_port_swap_capable_out <= 1'b1;
               end
            end
         end else if (feat_strobe_in && !feat_set_in && feat_ours) begin
            feat_ack_out <= swap_capable_in;
         end
      end
   end

   // Capability flags never gate swap once it is granted
   assign swap_allowed_out = role_swap_granted_out;
   assign use_other_port_out = other_port_swap_capable_out && !role_swap_granted_out;

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || flag_clear) begin
         swap_unsupported_out <= 1'b0;
      end else if (config_select_in) begin
         // Other-port flag alone still reads as unsupported here
         swap_unsupported_out <= !role_swap_granted_out &&
            !(host_port_swap_capable_out && !other_port_swap_capable_out);
      end
   end

   // Peripheral side role machine
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || is_host_side_in) begin
         p_reg <= drswp_pkg::PERIPH_DEFAULT_ROLE;
      end else begin
         unique case (p_reg)
            drswp_pkg::PERIPH_DEFAULT_ROLE: begin
               if (idle_long && role_swap_granted_out && periph_app_wants_bus_in) begin
                  p_reg <= drswp_pkg::PERIPH_AWAIT_HOST_ATTACH;
               end
            end
            drswp_pkg::PERIPH_AWAIT_HOST_ATTACH: begin
               if (j_to_k || line_state_in == drswp_pkg::LS_K || se0_long) begin
                  p_reg <= drswp_pkg::PERIPH_DEFAULT_ROLE;
               end else if (host_side_attached_out) begin
                  p_reg <= drswp_pkg::PERIPH_ACTING_HOST;
               end
            end
            drswp_pkg::PERIPH_ACTING_HOST: begin
               if (host_disconnect_in || host_done_in) begin
                  p_reg <= drswp_pkg::PERIPH_DEFAULT_ROLE;
               end
            end
            default: begin
               p_reg <= drswp_pkg::PERIPH_DEFAULT_ROLE;
            end
         endcase
      end
   end

   // A side switch resets the machine, so it must drop the attach flag too
   assign p_leave = is_host_side_in || ((p_reg == drswp_pkg::PERIPH_ACTING_HOST) &&
                    (host_disconnect_in || host_done_in));

   // Peripheral-side qualified events
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         host_suspend_seen_out <= 1'b0;
         host_resume_seen_out <= 1'b0;
         host_side_attached_out <= 1'b0;
         reset_inferred_out <= 1'b0;
      end else begin
         host_suspend_seen_out <= idle_long;
         host_resume_seen_out <= (p_reg == drswp_pkg::PERIPH_DEFAULT_ROLE) ? non_idle
            : (p_reg == drswp_pkg::PERIPH_AWAIT_HOST_ATTACH) &&
              (j_to_k || line_state_in == drswp_pkg::LS_K);
         reset_inferred_out <= (p_reg == drswp_pkg::PERIPH_AWAIT_HOST_ATTACH) && se0_long;
         if (p_leave || (p_reg == drswp_pkg::PERIPH_AWAIT_HOST_ATTACH &&
             (j_to_k || line_state_in == drswp_pkg::LS_K || se0_long))) begin
            host_side_attached_out <= 1'b0;
         end else if (p_reg == drswp_pkg::PERIPH_AWAIT_HOST_ATTACH &&
                      cnt_hit(att_cnt_reg, drswp_pkg::ATTACH_DEBOUNCE_CYC)) begin
            host_side_attached_out <= 1'b1;
         end
      end
   end

   // Host side role machine
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !is_host_side_in) begin
         h_reg <= drswp_pkg::HOST_DEFAULT_ROLE;
      end else begin
         unique case (h_reg)
            drswp_pkg::HOST_DEFAULT_ROLE: begin
               if (idle_long && host_quiet) begin
                  h_reg <= drswp_pkg::HOST_BUS_SUSPENDED;
               end
            end
            drswp_pkg::HOST_BUS_SUSPENDED: begin
               if (role_swap_granted_out && line_state_in == drswp_pkg::LS_SE0) begin
                  h_reg <= drswp_pkg::HOST_ACTING_PERIPH;
               end else if (role_swap_granted_out ? j_to_k : non_idle) begin
                  h_reg <= drswp_pkg::HOST_DEFAULT_ROLE;
               end else if (!host_quiet) begin
                  h_reg <= drswp_pkg::HOST_DEFAULT_ROLE;
               end
            end
            drswp_pkg::HOST_ACTING_PERIPH: begin
               if (idle_long) begin
                  h_reg <= drswp_pkg::HOST_AWAIT_PERIPH_ATTACH;
               end
            end
            drswp_pkg::HOST_AWAIT_PERIPH_ATTACH: begin
               if (periph_attach_in) begin
                  h_reg <= drswp_pkg::HOST_DEFAULT_ROLE;
               end
            end
         endcase
      end
   end

   // Host-side qualified events and session request flag
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         periph_suspend_seen_out <= 1'b0;
         periph_resume_seen_out <= 1'b0;
         session_request_seen_out <= 1'b0;
      end else begin
         periph_suspend_seen_out <= (h_reg == drswp_pkg::HOST_ACTING_PERIPH) && idle_long;
         periph_resume_seen_out <= (h_reg == drswp_pkg::HOST_BUS_SUSPENDED) &&
            (role_swap_granted_out ? j_to_k : non_idle);
         // Set wins over a clear in the same cycle
         if (supply_pulse_in || data_pulse_in) begin
            session_request_seen_out <= 1'b1;
         end else if (supply_fall_entry_in) begin
            session_request_seen_out <= 1'b0;
         end
      end
   end

   assign pullup_en_out = is_host_side_in ? (h_reg == drswp_pkg::HOST_ACTING_PERIPH)
                          : (p_reg == drswp_pkg::PERIPH_DEFAULT_ROLE);
   assign periph_state_out = p_reg;
   assign host_state_out = h_reg;
endmodule // drswp_core
`default_nettype wire

// ==== logic/drswp_pkg.sv ====
// Package for the dual-role swap feature and input qualifier block.
// Assumes a single 10 MHz device clock shared by every user.
package drswp_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // Feature selectors carried in wValue of SetFeature / ClearFeature
   localparam logic [7:0] SEL_ROLE_SWAP_GRANTED = 8'h03;
   localparam logic [7:0] SEL_HOST_PORT_SWAP = 8'h04;
   localparam logic [7:0] SEL_OTHER_PORT_SWAP = 8'h05;
   // Line state encodings
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J = 2'h1;
   localparam logic [1:0] LS_K = 2'h2;
   localparam logic [1:0] LS_SE1 = 2'h3;
   // Times in their printed units
   localparam int unsigned IDLE_SUSPEND_US = 3000;
   localparam int unsigned RESET_INFER_TIME_NS = 3_125_000;
   localparam int unsigned ATTACH_DEBOUNCE_TIME_NS = 2500;
   localparam int unsigned RESIDUAL_DISCHARGE_NS = 1000;
   // Cycle counts; "more than" figures count one past the time
   localparam int unsigned IDLE_SUSPEND_CYC = (IDLE_SUSPEND_US * (CLK_HZ / 1_000_000)) + 1;
   localparam int unsigned RESET_INFER_CYC =
      ((RESET_INFER_TIME_NS / 100) * (CLK_HZ / 10_000_000)) + 1;
   localparam int unsigned ATTACH_DEBOUNCE_CYC =
      ((ATTACH_DEBOUNCE_TIME_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
   localparam int unsigned RESIDUAL_DISCHARGE_CYC =
      ((RESIDUAL_DISCHARGE_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
   localparam int unsigned CNT_W = 16;
   // Peripheral-side role states, Gray along the usual path
   typedef enum logic [1:0] {
      PERIPH_DEFAULT_ROLE = 2'h0,
      PERIPH_AWAIT_HOST_ATTACH = 2'h1,
      PERIPH_ACTING_HOST = 2'h3
   } drswp_pstate_t;
   // Host-side role states
   typedef enum logic [1:0] {
      HOST_DEFAULT_ROLE = 2'h0,
      HOST_BUS_SUSPENDED = 2'h1,
      HOST_ACTING_PERIPH = 2'h3,
      HOST_AWAIT_PERIPH_ATTACH = 2'h2
   } drswp_hstate_t;
endpackage

// ==== verif/drswp_core_checker.sv ====
// Assertions on the ports of the role-swap block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module drswp_core_checker (
   input wire logic clk_in, sys_rst_in, swap_capable_in, is_host_side_in, // Control
   input wire logic [1:0] line_state_in, dev_state_in, periph_state_out, host_state_out, // State
   input wire logic bus_reset_in, session_end_in, feat_strobe_in, feat_set_in, // Requests
   input wire logic [7:0] feat_sel_in, // Selector
   input wire logic host_disconnect_in, supply_pulse_in, data_pulse_in, supply_fall_entry_in, // Events
   input wire logic feat_ack_out, feat_stall_out, role_swap_granted_out, swap_allowed_out, // Flags
   input wire logic host_port_swap_capable_out, other_port_swap_capable_out, use_other_port_out, // Flags
   input wire logic host_suspend_seen_out, periph_suspend_seen_out, host_resume_seen_out, // Events
   input wire logic host_side_attached_out, session_request_seen_out, pullup_en_out // Status
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [15:0] idle_cnt;
   // A same-cycle clear overrides the request, so no answer is due then
   wire logic ok_req = feat_strobe_in && feat_sel_in >= 8'h03 && feat_sel_in <= 8'h05
      && dev_state_in != 2'h3 && !bus_reset_in && !session_end_in;
   // Own count of idle cycles, independent of the design's counter
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || line_state_in != drswp_pkg::LS_J) begin
         idle_cnt <= 16'h0000;
      end else if (idle_cnt != 16'hffff) begin
         idle_cnt <= idle_cnt + 16'h0001;
      end
   end
   sequence s_se0_granted;
      is_host_side_in && host_state_out == 2'h1 && role_swap_granted_out
         && line_state_in == drswp_pkg::LS_SE0;
   endsequence
   sequence s_handoff;
      host_state_out == 2'h3 && pullup_en_out;
   endsequence
   property p_ack; ok_req && swap_capable_in |=> feat_ack_out && !feat_stall_out; endproperty
   property p_stall; ok_req && feat_set_in && !swap_capable_in |=> feat_stall_out; endproperty
   property p_hold;
      !bus_reset_in && !session_end_in |=> !$fell(role_swap_granted_out)
         && !$fell(host_port_swap_capable_out) && !$fell(other_port_swap_capable_out);
   endproperty
   property p_clear;
      bus_reset_in || session_end_in |=> !role_swap_granted_out
         && !host_port_swap_capable_out && !other_port_swap_capable_out;
   endproperty
   property p_allow; swap_allowed_out == role_swap_granted_out; endproperty
   property p_other;
      use_other_port_out == (other_port_swap_capable_out && !role_swap_granted_out);
   endproperty
   property p_sreq; supply_pulse_in || data_pulse_in |=> session_request_seen_out; endproperty
   property p_sclr;
      supply_fall_entry_in && !supply_pulse_in && !data_pulse_in |=> !session_request_seen_out;
   endproperty
   property p_resume;
      !is_host_side_in && periph_state_out == 2'h0 && line_state_in == drswp_pkg::LS_K
         |=> host_resume_seen_out;
   endproperty
   property p_idle_lo;
      idle_cnt < 16'(drswp_pkg::IDLE_SUSPEND_CYC - 10) |=> !host_suspend_seen_out
         && !periph_suspend_seen_out;
   endproperty
   property p_idle_hi;
      !is_host_side_in && idle_cnt == 16'(drswp_pkg::IDLE_SUSPEND_CYC + 5)
         |-> host_suspend_seen_out;
   endproperty
   property p_handoff; s_se0_granted |-> ##[1:2] s_handoff; endproperty
   property p_attach;
      $rose(host_side_attached_out) |-> idle_cnt >= 16'(drswp_pkg::ATTACH_DEBOUNCE_CYC);
   endproperty
   property p_disc;
      !is_host_side_in && periph_state_out == 2'h3 && host_disconnect_in
         |=> !host_side_attached_out;
   endproperty
   property p_se0_hold;
      !is_host_side_in && periph_state_out == 2'h1 && line_state_in == drswp_pkg::LS_SE0
         |=> !host_resume_seen_out;
   endproperty
   a_ack: assert property (p_ack) else $error("request not acknowledged");
   a_stall: assert property (p_stall) else $error("request not stalled");
   a_hold: assert property (p_hold) else $error("flag dropped without clear");
   a_clear: assert property (p_clear) else $error("flag kept after clear");
   a_allow: assert property (p_allow) else $error("swap allowed wrong");
   a_other: assert property (p_other) else $error("other port advice wrong");
   a_sreq: assert property (p_sreq) else $error("session request missed");
   a_sclr: assert property (p_sclr) else $error("session request kept");
   a_resume: assert property (p_resume) else $error("resume missed");
   a_idle_lo: assert property (p_idle_lo) else $error("suspend too early");
   a_idle_hi: assert property (p_idle_hi) else $error("suspend missed");
   a_handoff: assert property (p_handoff) else $error("handoff missed");
   a_attach: assert property (p_attach) else $error("attach too early");
   a_disc: assert property (p_disc) else $error("attach kept after disconnect");
   a_se0_hold: assert property (p_se0_hold) else $error("SE0 taken as resume");
endmodule // drswp_core_checker
bind drswp_core drswp_core_checker chk_u (.*);
`default_nettype wire

// ==== verif/drswp_core_tb_top.sv ====
// Self-checking bench for the role-swap flags and line qualifiers.
// Assumes a 10 MHz clock; the long idle waits set the run length.
`timescale 1ns/10ps
`default_nettype none
module drswp_core_tb_top;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic cap = 1'b1, hs = 1'b0, stb = 1'b0, fset = 1'b0, hwant = 1'b0, pwant = 1'b0;
   logic pdn = 1'b0;
   logic [7:0] fsel = 8'h00;
   logic [1:0] dst = 2'h0, tgt = 2'h0;
   logic [1:0] line;
   logic [7:0] pv = 8'h00;
   wire logic ack, stall, gr, hp, op, allow, useo, unsup, hsus, hres, hatt, psus, sreq, pu;
   wire logic rinf, pres;
   wire logic [1:0] pst, hst;
   int fail_count = 0;
   int comparisons = 0;
   always #50 clk_in = ~clk_in;
   drswp_line_partner line_u (.clk_in(clk_in), .target_in(tgt), .line_state_out(line));
   drswp_core dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .swap_capable_in(cap),
      .is_host_side_in(hs), .line_state_in(line), .bus_reset_in(pv[0]), .session_end_in(pv[1]),
      .feat_strobe_in(stb), .feat_set_in(fset), .feat_sel_in(fsel), .dev_state_in(dst),
      .config_select_in(pv[2]), .host_disconnect_in(pv[6]), .host_done_in(1'b0),
      .supply_pulse_in(pv[3]), .data_pulse_in(pv[4]), .supply_fall_entry_in(pv[5]),
      .periph_attach_in(pv[7]), .host_app_wants_bus_in(hwant), .host_app_power_down_in(pdn),
      .periph_app_wants_bus_in(pwant), .feat_ack_out(ack), .feat_stall_out(stall),
      .role_swap_granted_out(gr), .host_port_swap_capable_out(hp),
      .other_port_swap_capable_out(op), .swap_allowed_out(allow), .use_other_port_out(useo),
      .swap_unsupported_out(unsup), .host_suspend_seen_out(hsus), .host_resume_seen_out(hres),
      .host_side_attached_out(hatt), .reset_inferred_out(rinf), .periph_suspend_seen_out(psus),
      .periph_resume_seen_out(pres), .session_request_seen_out(sreq), .pullup_en_out(pu),
      .periph_state_out(pst), .host_state_out(hst));
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Answer is looked at in the one cycle it stands
   task automatic feat(input logic s, input logic [7:0] sel, input logic [1:0] d,
      input logic [3:0] exp);
      @(posedge clk_in);
      stb <= 1'b1;
      fset <= s;
      fsel <= sel;
      dst <= d;
      @(posedge clk_in);
      stb <= 1'b0;
      #1;
      chk({2'b00, ack, stall}, exp);
   endtask
   task automatic pulse(input int b);
      @(posedge clk_in);
      pv[b] <= 1'b1;
      @(posedge clk_in);
      pv <= 8'h00;
      #1;
   endtask
   task automatic drive(input logic [1:0] v);
      @(posedge clk_in);
      tgt <= v;
   endtask
   task automatic await_state(input logic host, input logic [1:0] v, input int n);
      for (int i = 0; i < n && (host ? hst : pst) !== v; i++) begin
         tick(1);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      tick(1);
      chk({1'b0, gr, hp, op}, 4'h0);
      for (int i = 0; i < 3; i++) begin
         feat(1'b1, 8'h03 + 8'(i), 2'(i), 4'h2);
         feat(1'b0, 8'h03 + 8'(i), 2'(i), 4'h2);
      end
      chk({1'b0, gr, hp, op}, 4'h7);
      chk({2'b00, allow, useo}, 4'h2);
      pulse(0);
      chk({1'b0, gr, hp, op}, 4'h0);
      feat(1'b1, 8'h04, 2'h0, 4'h2);
      feat(1'b1, 8'h05, 2'h2, 4'h2);
      chk({2'b00, allow, useo}, 4'h1);
      pulse(2);
      chk({3'b000, unsup}, 4'h1);
      pulse(1);
      chk({1'b0, gr, hp, op}, 4'h0);
      feat(1'b1, 8'h04, 2'h1, 4'h2);
      pulse(2);
      chk({3'b000, unsup}, 4'h0);
      @(posedge clk_in);
      cap <= 1'b0;
      feat(1'b1, 8'h03, 2'h0, 4'h1);
      @(posedge clk_in);
      cap <= 1'b1;
      feat(1'b1, 8'h03, 2'h3, 4'h0);
      feat(1'b1, 8'h06, 2'h0, 4'h0);
      chk({1'b0, gr, hp, op}, 4'h2);
      pulse(3);
      chk({3'b000, sreq}, 4'h1);
      pulse(5);
      chk({3'b000, sreq}, 4'h0);
      pulse(4);
      chk({3'b000, sreq}, 4'h1);
      drive(drswp_pkg::LS_J);
      tick(3);
      chk({3'b000, hres}, 4'h0);
      drive(drswp_pkg::LS_K);
      tick(3);
      chk({3'b000, hres}, 4'h1);
      feat(1'b1, 8'h03, 2'h2, 4'h2);
      @(posedge clk_in);
      pwant <= 1'b1;
      drive(drswp_pkg::LS_J);
      tick(29990);
      chk({1'b0, pst, hsus}, 4'h0);
      await_state(1'b0, 2'h1, 40);
      chk({1'b0, pst, hsus}, 4'h3);
      drive(drswp_pkg::LS_SE0);
      tick(100);
      chk({2'b00, pst}, 4'h1);
      chk({2'b00, hres, rinf}, 4'h0);
      drive(drswp_pkg::LS_J);
      await_state(1'b0, 2'h3, 60);
      chk({1'b0, pst, hatt}, 4'h7);
      pulse(6);
      chk({3'b000, hatt}, 4'h0);
      drive(drswp_pkg::LS_SE0);
      @(posedge clk_in);
      hs <= 1'b1;
      hwant <= 1'b0;
      pdn <= 1'b1;
      drive(drswp_pkg::LS_J);
      await_state(1'b1, 2'h1, 30100);
      chk({2'b00, hst}, 4'h1);
      drive(drswp_pkg::LS_SE0);
      tick(2);
      chk({3'b000, pres}, 4'h0);
      tick(1);
      chk({1'b0, hst, pu}, 4'h7);
      drive(drswp_pkg::LS_J);
      tick(29990);
      chk({2'b00, hst}, 4'h3);
      await_state(1'b1, 2'h2, 40);
      chk({2'b00, hst}, 4'h2);
      pulse(7);
      chk({2'b00, hst}, 4'h0);
      tally_and_finish();
   end
   // Main sequence needs about 90k cycles; cut off just short of 100k
   initial begin
      #9_900_000;
      fail_count++;
      tally_and_finish();
   end
endmodule // drswp_core_tb_top
`default_nettype wire

// ==== verif/drswp_line_partner.sv ====
// Far-end line driver: puts the level the far end wants on the bus.
// Assumes the bench names the level; a released bus is given as SE0.
`timescale 1ns/10ps
`default_nettype none
module drswp_line_partner (
   input wire logic clk_in, // Device clock
   input wire logic [1:0] target_in, // Level the far end drives
   output logic [1:0] line_state_out = 2'h0 // Level seen by the device
);
   // Registered, so each change lands one cycle after it is asked for
   always @(posedge clk_in) begin
      line_state_out <= target_in;
   end
endmodule // drswp_line_partner
`default_nettype wire
